// ==== rtl/datalog_defines.svh ====
// Constants for the data-logger mission control block.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef DATALOG_DEFINES_SVH
`define DATALOG_DEFINES_SVH

// Register byte offsets on the bus.
`define OFS_CTRL     8'h00
`define OFS_RATE     8'h04
`define OFS_DELAY    8'h08
`define OFS_CHAN     8'h0c
`define OFS_TIME     8'h10
`define OFS_DATE     8'h14
`define OFS_ALARM    8'h18
`define OFS_STATUS   8'h1c
`define OFS_INT_STAT 8'h20
`define OFS_INT_MASK 8'h24
`define OFS_COUNT    8'h28

// Control register fields.
`define CTRL_METHOD  0
`define CTRL_ROLL    1
`define CTRL_BEGIN   4
`define CTRL_END     5
`define CTRL_CLEAR   6

// Alarm word fields.
`define ALARM_EN     24

// Calendar limits.
`define MIN_MAX      6'h3b
`define HOUR_MAX     5'h17
`define DOW_MIN      3'h1
`define DOW_MAX      3'h7
`define YEAR_MAX     7'h63

// Log memory address width.
`define LOG_AW       11

// Pushbutton hold time and clock rate.
`define DBNC_TIME_MS 500
`define CLK_KHZ      25000

`endif

// ==== rtl/datalog_pkg.sv ====
// Types shared by the data-logger mission control block.
// Assumes the constants header sits beside it.
`include "datalog_defines.svh"

package datalog_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_LOG   = 2'b10,
    ST_DONE  = 2'b11
  } mission_state_t;

  typedef struct packed {
    logic [2:0] dow;
    logic [4:0] hour;
    logic [5:0] minute;
  } tod_t;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
  } date_t;

  typedef struct packed {
    logic mem_full;
    logic refused;
    logic alarm;
    logic ended;
  } events_t;

  typedef struct packed {
    logic [3:0]             chan;
    logic [`LOG_AW-1:0]     addr;
  } sample_t;

endpackage : datalog_pkg

// ==== rtl/datalog_mission_control.sv ====
// Mission control of a minute-based temperature and data recorder.
// Assumes an AHB-Lite master, a one-cycle minute tick from the clock,
// and a pushbutton input already synchronous to clk.
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "datalog_defines.svh"

// Notes on behaviour
// (RULE1) Unconnected interface select means asynchronous port.
// (RULE2) Synchronous port uses clock, data, reset pins.
// (RULE3) Active-low interrupt output beside synchronous pins.
// (RULE4) Sample interval holds 1 to 255 minutes.
// (RULE5) Zero interval refuses mission start.
// (RULE6) Start delay minutes pass before first sample.
// (RULE7) Rollover overwrites oldest data when full.
// (RULE8) Serial method starts on begin command.
// (RULE9) Button method needs half-second continuous hold.
// (RULE10) End command stops sampling, data kept.
// (RULE11) Any write during a mission ends it.
// (RULE12) Host clears log memory before new mission.
// (RULE13) Only enabled channels are logged.
// (RULE14) Day of week runs 1 to 7.
// (RULE15) Two-digit year, calendar loaded before start.
// (RULE16) Alarm flag set on time alarm match.
// (RULE17) Sample at every interval boundary until end.
module datalog_mission_control #(
  parameter int DEBOUNCE_CYCLES = `DBNC_TIME_MS * `CLK_KHZ
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hsel,
  input  wire logic                 hready,
  output var  logic [31:0]          hrdata,
  output var  logic                 hreadyout,
  output var  logic                 hresp,
  input  wire logic                 interface_select,
  input  wire logic                 sclk,
  input  wire logic                 io_in,
  output var  logic                 io_out,
  output var  logic                 io_oe_n,
  input  wire logic                 comm_rst_n,
  output var  logic                 int_n,
  output var  logic                 irq,
  input  wire logic                 minute_tick,
  input  wire logic                 button,
  output var  logic                 sample_req,
  output var  datalog_pkg::sample_t sample_info
);
  import datalog_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Counts a calendar field up and wraps it back to its floor.
  function automatic logic [5:0] wrap_inc(input logic [5:0] v,
                                          input logic [5:0] top,
                                          input logic [5:0] low);
    wrap_inc = (v >= top) ? low : 6'(v + 6'h01);
  endfunction : wrap_inc

  // Forces a day of week into the legal range.
  function automatic logic [2:0] fix_dow(input logic [2:0] d);
    fix_dow = (d < `DOW_MIN) ? `DOW_MIN : d;
  endfunction : fix_dow

  // Packs a time of day into its register word.
  function automatic logic [31:0] tod_word(input tod_t t);
    tod_word = {13'h0000, t.dow, 3'h0, t.hour, 2'h0, t.minute};
  endfunction : tod_word

  // ****************************************************************
  // State
  // ****************************************************************

  localparam logic [23:0] DBNC_LAST = 24'(DEBOUNCE_CYCLES - 1);
  localparam logic [23:0] DBNC_FULL = 24'(DEBOUNCE_CYCLES);

  mission_state_t      state_reg, state_next;
  logic [6:0]          ctrl_reg;
  logic [7:0]          rate_reg;
  logic [7:0]          delay_reg;
  logic [3:0]          chan_reg;
  tod_t                tod_reg;
  date_t               date_reg;
  tod_t                alarm_reg;
  logic                alarm_en_reg;
  events_t             stat_reg, mask_reg;
  logic [7:0]          cnt_reg;
  logic [`LOG_AW-1:0]  ptr_reg;
  logic                full_reg;
  logic [23:0]         btn_cnt_reg;
  logic                btn_start_reg;
  logic                async_sel_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_ofs_reg;

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  // Address phase accepted when selected, active and the bus is ready.
  wire        acc       = hsel & hready & htrans[1];
  wire        rd_acc    = acc & ~hwrite;
  wire [7:0]  ofs       = haddr[7:0];
  wire        wr_en     = wr_pend_reg;
  wire        wr_ctrl   = wr_en & (wr_ofs_reg == `OFS_CTRL);
  wire        begin_cmd = wr_ctrl & hwdata[`CTRL_BEGIN];
  wire        end_cmd   = wr_ctrl & hwdata[`CTRL_END];
  wire        clear_cmd = wr_ctrl & hwdata[`CTRL_CLEAR];
  wire        active    = (state_reg == ST_DELAY) | (state_reg == ST_LOG);
  wire        method_btn = ctrl_reg[`CTRL_METHOD];
  wire        rollover  = ctrl_reg[`CTRL_ROLL];

  // Start request from the chosen method.
  wire start_req = method_btn ? btn_start_reg : begin_cmd; // see (RULE8) see (RULE9)
  wire start_ok  = start_req & (rate_reg != 8'h00);        // see (RULE5)

  // A sample is due on a minute boundary once the count runs out.
  wire sample_now = minute_tick & (cnt_reg == 8'h00) & active; // see (RULE6) see (RULE17)
  wire stop_full  = sample_now & full_reg & ~rollover;        // see (RULE7)

  // Alarm matches on minute, hour and day of week.
  wire alarm_hit = alarm_en_reg & (tod_reg == alarm_reg);     // see (RULE16)

  wire [2:0] st_word = {async_sel_reg, state_reg};
  wire sync_link = ~async_sel_reg & comm_rst_n;               // see (RULE2)

  // Read multiplexer, sampled in the address phase.
  logic [31:0] rd_mux;
  always_comb begin
    unique case (ofs)
      `OFS_CTRL:     rd_mux = {25'h0, ctrl_reg & 7'h03};
      `OFS_RATE:     rd_mux = {24'h0, rate_reg};
      `OFS_DELAY:    rd_mux = {24'h0, delay_reg};
      `OFS_CHAN:     rd_mux = {28'h0, chan_reg};
      `OFS_TIME:     rd_mux = tod_word(tod_reg);
      `OFS_DATE:     rd_mux = {9'h000, date_reg.year, 4'h0, date_reg.month,
                               3'h0, date_reg.day};
      `OFS_ALARM:    rd_mux = tod_word(alarm_reg) | {7'h00, alarm_en_reg, 24'h0};
      `OFS_STATUS:   rd_mux = {26'h0, sync_link, btn_start_reg, full_reg, st_word};
      `OFS_INT_STAT: rd_mux = {28'h0, stat_reg};
      `OFS_INT_MASK: rd_mux = {28'h0, mask_reg};
      `OFS_COUNT:    rd_mux = {21'h0, ptr_reg};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Events of this cycle; a read of the interrupt status word clears older ones.
  wire events_t ev = '{mem_full: stop_full | (sample_now & full_reg),
                       refused:  start_req & ~start_ok & (state_reg != ST_LOG),
                       alarm:    alarm_hit,
                       ended:    (active & (wr_en | stop_full))};
  wire rd_stat = rd_acc & (ofs == `OFS_INT_STAT);
  wire events_t stat_next = (rd_stat ? 4'h0 : stat_reg) | ev; // Set wins.

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  // Zero-wait slave: read data registered at the address phase edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
    end else begin
      hrdata      <= rd_acc ? rd_mux : 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= acc & hwrite;
      wr_ofs_reg  <= ofs;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  // Host writes land in the data phase.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg     <= 7'h00;
      rate_reg     <= 8'h00;
      delay_reg    <= 8'h00;
      chan_reg     <= 4'h1;
      alarm_reg    <= '{dow: `DOW_MIN, hour: 5'h00, minute: 6'h00};
      alarm_en_reg <= 1'b0;
      date_reg     <= '{year: 7'h00, month: 4'h1, day: 5'h01};
      mask_reg     <= 4'h0;
    end else if (wr_en) begin
      unique case (wr_ofs_reg)
        `OFS_CTRL:     ctrl_reg  <= hwdata[6:0] & 7'h03;
        `OFS_RATE:     rate_reg  <= hwdata[7:0];                  // see (RULE4)
        `OFS_DELAY:    delay_reg <= hwdata[7:0];
        `OFS_CHAN:     chan_reg  <= hwdata[3:0];                  // see (RULE13)
        `OFS_DATE:     date_reg  <= '{year: (hwdata[22:16] > `YEAR_MAX) ? 7'h00
                                      : hwdata[22:16],            // see (RULE15)
                                      month: hwdata[11:8], day: hwdata[4:0]};
        `OFS_ALARM: begin
          alarm_reg    <= '{dow: fix_dow(hwdata[18:16]), hour: hwdata[12:8],
                            minute: hwdata[5:0]};
          alarm_en_reg <= hwdata[`ALARM_EN];
        end
        `OFS_INT_MASK: mask_reg  <= hwdata[3:0];
        default:       ctrl_reg  <= ctrl_reg;
      endcase
    end
  end

  // Time of day: loaded by the host, advanced on each minute tick.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tod_reg <= '{dow: `DOW_MIN, hour: 5'h00, minute: 6'h00};
    end else if (wr_en && wr_ofs_reg == `OFS_TIME) begin
      tod_reg <= '{dow: fix_dow(hwdata[18:16]), hour: hwdata[12:8],
                   minute: hwdata[5:0]};                          // see (RULE14)
    end else if (minute_tick) begin
      tod_reg.minute <= wrap_inc(tod_reg.minute, `MIN_MAX, 6'h00);
      if (tod_reg.minute >= `MIN_MAX) begin
        tod_reg.hour <= 5'(wrap_inc({1'b0, tod_reg.hour}, {1'b0, `HOUR_MAX}, 6'h00));
        if (tod_reg.hour >= `HOUR_MAX) begin
          tod_reg.dow <= 3'(wrap_inc({3'h0, tod_reg.dow}, {3'h0, `DOW_MAX},
                                     {3'h0, `DOW_MIN}));           // see (RULE14)
        end
      end
    end
  end

  // ****************************************************************
  // Pushbutton and interface select
  // ****************************************************************

  // The button must stay pressed for the full hold time.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      btn_cnt_reg   <= 24'h00_0000;
      btn_start_reg <= 1'b0;
    end else begin
      btn_cnt_reg   <= !button ? 24'h00_0000
                     : (btn_cnt_reg == DBNC_FULL) ? btn_cnt_reg
                     : 24'(btn_cnt_reg + 24'h00_0001);            // see (RULE9)
      // One pulse per hold: the count parks one past the firing value.
      btn_start_reg <= button & (btn_cnt_reg == DBNC_LAST);
    end
  end

  // Low select, as left by the internal pulldown, picks asynchronous.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      async_sel_reg <= 1'b1;
    end else begin
      async_sel_reg <= ~interface_select;                         // see (RULE1)
    end
  end

  // ****************************************************************
  // Mission sequencer
  // ****************************************************************

  // Next state of the mission.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (start_ok) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY, ST_LOG: begin
        if (wr_en || stop_full) begin
          state_next = ST_DONE;                                   // see (RULE10) see (RULE11)
        end else if (sample_now) begin
          state_next = ST_LOG;
        end
      end
    endcase
  end

  // Minute counter, log pointer and full flag.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 8'h00;
      ptr_reg   <= '0;
      full_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (!active && start_ok) begin
        cnt_reg <= delay_reg;                                     // see (RULE6)
      end else if (sample_now) begin
        cnt_reg <= 8'(rate_reg - 8'h01);                          // see (RULE17)
      end else if (minute_tick && active) begin
        cnt_reg <= 8'(cnt_reg - 8'h01);
      end
      if (clear_cmd && !active) begin
        ptr_reg  <= '0;
        full_reg <= 1'b0;
      end else if (sample_now && !stop_full && !wr_en) begin
        ptr_reg  <= `LOG_AW'(ptr_reg + 1'b1);                     // see (RULE7)
        full_reg <= full_reg | (&ptr_reg);
      end
    end
  end

  // ****************************************************************
  // Interrupts and sample outputs
  // ****************************************************************

  // Sticky events, masked onto both interrupt outputs.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg    <= 4'h0;
      irq         <= 1'b0;
      int_n       <= 1'b1;
      sample_req  <= 1'b0;
      sample_info <= '0;
      io_out      <= 1'b0;
      io_oe_n     <= 1'b1;
    end else begin
      stat_reg    <= stat_next;                                   // see (RULE16)
      irq         <= |(stat_next & mask_reg);
      int_n       <= ~|(stat_next & mask_reg);                    // see (RULE3)
      sample_req  <= sample_now & ~stop_full & ~wr_en & (chan_reg != 4'h0);
      sample_info <= '{chan: chan_reg, addr: ptr_reg};            // see (RULE13)
      io_out      <= 1'b0;
      io_oe_n     <= 1'b1;                                        // Line released.
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sel_default_a: assert property (!interface_select |=> async_sel_reg) // see (RULE1)
    else $error("Open select did not pick asynchronous port.");
  int_pin_level_a: assert property (|(stat_next & mask_reg) |=> !int_n && irq) // see (RULE3)
    else $error("Interrupt pin not low with pending event.");
  zero_rate_a: assert property (state_reg == ST_IDLE && rate_reg == 8'h00
                                |=> state_reg == ST_IDLE) // see (RULE5)
    else $error("Mission started with zero interval.");
  delay_hold_a: assert property (state_reg == ST_DELAY && minute_tick && cnt_reg != 8'h00
                                 |=> !sample_req) // see (RULE6)
    else $error("Sample taken inside start delay.");
  roll_on_a: assert property (sample_now && full_reg && rollover && !wr_en
                              |=> state_reg == ST_LOG && sample_req == (chan_reg != 4'h0)) // see (RULE7)
    else $error("Rollover did not keep logging.");
  serial_go_a: assert property (!active && begin_cmd && !method_btn // see (RULE8)
                                && rate_reg != 8'h00 |=> state_reg == ST_DELAY) // see (RULE8)
    else $error("Begin command did not start mission.");
  button_hold_a: assert property (state_reg == ST_IDLE && method_btn && !btn_start_reg
                                  |=> state_reg == ST_IDLE) // see (RULE9)
    else $error("Mission started without full button hold.");
  end_keep_a: assert property (active && end_cmd |=> state_reg == ST_DONE
                               && $stable(ptr_reg) ##1 $stable(ptr_reg)) // see (RULE10)
    else $error("End command lost data or kept sampling.");
  write_abort_a: assert property (active && wr_en |=> state_reg == ST_DONE) // see (RULE11)
    else $error("Write during mission did not end it.");
  dow_range_a: assert property (tod_reg.dow >= `DOW_MIN && tod_reg.dow <= `DOW_MAX) // see (RULE14)
    else $error("Day of week out of range.");
  alarm_flag_a: assert property (alarm_hit && !rd_stat |=> stat_reg.alarm) // see (RULE16)
    else $error("Alarm match did not set flag.");
  interval_a: assert property (state_reg == ST_LOG && sample_now && !full_reg && !wr_en
                               && chan_reg != 4'h0 |=> sample_req
                               && cnt_reg == 8'($past(rate_reg) - 8'h01)) // see (RULE17)
    else $error("Interval boundary did not sample.");

  start_cov: cover property (state_reg == ST_IDLE ##1 state_reg == ST_DELAY);
  log_cov:   cover property (state_reg == ST_DELAY ##1 state_reg == ST_LOG);
  abort_cov: cover property (state_reg == ST_LOG && wr_en ##1 state_reg == ST_DONE);

endmodule : datalog_mission_control
`default_nettype wire

// ==== dv/host_model.sv ====
// Host controller model that reaches the mission control registers over AHB-Lite.
// Assumes a single slave whose ready output is fed back as hready.
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  output var  logic        hsel
);

  // The bus sits idle until the first transfer.
  initial begin
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hsel = 1'b0;
  end

  // One single word transfer; ready and read data are taken at the rising edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

endmodule : host_model

`default_nettype wire

// ==== dv/datalog_mission_control_tb.sv ====
// Self-checking bench for the mission control block.
// Assumes the host model beside it and a shortened pushbutton hold time.
`timescale 1ns/1ns
`default_nettype none

module datalog_mission_control_tb;
  import datalog_pkg::*;

  logic clk = 1'b0, nrst = 1'b0, minute_tick = 1'b0, button = 1'b0;
  logic        interface_select = 1'b0, comm_rst_n = 1'b1;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite, hsel, hreadyout, hresp, io_out, io_oe_n, int_n, irq, sample_req;
  sample_t     sample_info;
  int          fail_count = 0, tests_run = 0, samples = 0;

  always #20 clk = ~clk;

  host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel));

  datalog_mission_control #(.DEBOUNCE_CYCLES(16)) dut (.clk(clk), .nrst(nrst),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .interface_select(interface_select), .sclk(1'b0), .io_in(1'b1), .io_out(io_out),
    .io_oe_n(io_oe_n), .comm_rst_n(comm_rst_n), .int_n(int_n), .irq(irq),
    .minute_tick(minute_tick),
    .button(button), .sample_req(sample_req), .sample_info(sample_info));

  // Counts logged samples; the pulse lasts one cycle.
  always @(posedge clk) begin
    if (sample_req === 1'b1) samples <= samples + 1;
  end

  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask : rd

  // One minute tick, then time for the sample pulse to land.
  task tick;
    @(posedge clk) minute_tick <= 1'b1;
    @(posedge clk) minute_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : tick

  task hold(input int n);
    @(posedge clk) button <= 1'b1;
    repeat (n) @(posedge clk);
    button <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : hold

  task test_done;
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({hreadyout, hresp, int_n, irq, io_oe_n, io_out}, 32'h2a);
    rd(8'h0c, 32'h1, 32'hf);
    rd(8'h40, 32'h0, 32'hffffffff);
    rd(8'h1c, 32'h4, 32'h7);
    interface_select <= 1'b1;
    rd(8'h1c, 32'h20, 32'h24);
    comm_rst_n <= 1'b0;
    rd(8'h1c, 32'h0, 32'h24);
    interface_select <= 1'b0;
    comm_rst_n <= 1'b1;
    rd(8'h1c, 32'h4, 32'h24);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h10);
    rd(8'h1c, 32'h0, 32'h3);
    rd(8'h20, 32'h4, 32'hf);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h1);
    hold(10);
    rd(8'h1c, 32'h0, 32'h3);
    hold(20);
    rd(8'h1c, 32'h1, 32'h3);
    wr(8'h00, 32'h20);
    rd(8'h1c, 32'h3, 32'h3);
    rd(8'h20, 32'h1, 32'hf);
    wr(8'h10, 32'h00000c0f);
    rd(8'h10, 32'h00010c0f, 32'h71f3f);
    wr(8'h14, 32'h00640101);
    rd(8'h14, 32'h00000101, 32'h7f0f1f);
    wr(8'h18, 32'h01010c0f);
    rd(8'h20, 32'h2, 32'h2);
    wr(8'h18, 32'h0);
    rd(8'h20, 32'h2, 32'hf);
    rd(8'h20, 32'h0, 32'hf);
    wr(8'h00, 32'h40);
    rd(8'h28, 32'h0, 32'h7ff);
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h5);
    wr(8'h24, 32'h1);
    wr(8'h00, 32'h12);
    rd(8'h1c, 32'h1, 32'h3);
    tick();
    chk(samples, 32'h0);
    tick();
    chk(samples, 32'h1);
    chk({28'h0, sample_info.chan}, 32'h5);
    chk({21'h0, sample_info.addr}, 32'h1);
    rd(8'h1c, 32'h2, 32'h3);
    tick();
    chk(samples, 32'h1);
    tick();
    chk(samples, 32'h2);
    chk({int_n, irq}, 32'h2);
    wr(8'h04, 32'h2);
    tick();
    chk(samples, 32'h2);
    rd(8'h1c, 32'h3, 32'h3);
    rd(8'h28, 32'h2, 32'h7ff);
    chk({int_n, irq}, 32'h1);
    host.xfer(1'b0, 8'h20, 32'h0, q);
    chk({int_n, irq}, 32'h2);
    chk(q & 32'hf, 32'h1);
    repeat (2) @(posedge clk);
    chk({int_n, irq}, 32'h2);
    test_done();
  end

  // Cuts a hang short; the sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

endmodule : datalog_mission_control_tb

`default_nettype wire
